//--- ipr_bank.sv
// Purpose: Interrupt priority register bank with a priority arbiter
// Assumes: Flags and enables come from logic on i_clk; register port is one cycle
// Notes:   Unmapped reads return zero, unmapped writes are dropped
`timescale 1ns/10ps
module ipr_bank (
  // Clock, reset, enable
  input  wire logic                              i_clk,
  input  wire logic                              i_rst,
  input  wire logic                              i_ce,
  // Register port
  input  wire logic [ipr_pkg::ADDR_W-1:0]        i_addr,
  input  wire logic [ipr_pkg::REG_W-1:0]         i_wdata,
  input  wire logic                              i_wr,
  input  wire logic                              i_rd,
  output logic      [ipr_pkg::REG_W-1:0]         o_rdata,
  // Interrupt sources
  input  wire logic [ipr_pkg::NUM_SRC-1:0]       i_flag,
  input  wire logic [ipr_pkg::NUM_SRC-1:0]       i_enable,
  // Request to the processor
  output logic                                   o_irq_req,
  output logic      [ipr_pkg::FLD_W-1:0]         o_irq_level,
  output logic      [ipr_pkg::SRC_W-1:0]         o_irq_src,
  // Field values, register two
  output logic      [ipr_pkg::FLD_W-1:0]         o_serial1_rx_prio,
  output logic      [ipr_pkg::FLD_W-1:0]         o_spi_a_event_prio,
  output logic      [ipr_pkg::FLD_W-1:0]         o_spi_a_fault_prio,
  output logic      [ipr_pkg::FLD_W-1:0]         o_timer_c_prio,
  // Field values, register three
  output logic      [ipr_pkg::FLD_W-1:0]         o_convert_done_prio,
  output logic      [ipr_pkg::FLD_W-1:0]         o_serial1_tx_prio,
  // Field values, register four
  output logic      [ipr_pkg::FLD_W-1:0]         o_input_change_prio,
  output logic      [ipr_pkg::FLD_W-1:0]         o_comparator_prio,
  output logic      [ipr_pkg::FLD_W-1:0]         o_twowire_a_master_prio,
  output logic      [ipr_pkg::FLD_W-1:0]         o_twowire_a_slave_prio,
  // Field values, register five
  output logic      [ipr_pkg::FLD_W-1:0]         o_capture_h_prio,
  output logic      [ipr_pkg::FLD_W-1:0]         o_capture_g_prio,
  output logic      [ipr_pkg::FLD_W-1:0]         o_ext_line_b_prio,
  // Field values, register six
  output logic      [ipr_pkg::FLD_W-1:0]         o_timer_d_prio,
  output logic      [ipr_pkg::FLD_W-1:0]         o_compare_d_prio,
  output logic      [ipr_pkg::FLD_W-1:0]         o_compare_c_prio,
  // Field values, register seven
  output logic      [ipr_pkg::FLD_W-1:0]         o_serial2_tx_prio,
  output logic      [ipr_pkg::FLD_W-1:0]         o_serial2_rx_prio,
  output logic      [ipr_pkg::FLD_W-1:0]         o_ext_line_c_prio,
  output logic      [ipr_pkg::FLD_W-1:0]         o_timer_e_prio,
  // Field values, register eight
  output logic      [ipr_pkg::FLD_W-1:0]         o_spi_b_event_prio,
  output logic      [ipr_pkg::FLD_W-1:0]         o_spi_b_fault_prio
);

  // All field values, source k at bits k*3 upward
  logic [ipr_pkg::NUM_SRC*ipr_pkg::FLD_W-1:0] prio_all;
  // Sources that are flagged and enabled
  logic [ipr_pkg::NUM_SRC-1:0]                pending;
  // Arbiter result before the output flops
  logic                                       win_valid;
  logic [ipr_pkg::FLD_W-1:0]                  win_level;
  logic [ipr_pkg::SRC_W-1:0]                  win_src;
  // Register image at the read address
  logic [ipr_pkg::REG_W-1:0]                  rd_word;
  // Registered read data and request
  logic [ipr_pkg::REG_W-1:0]                  rdata_q;
  logic                                       req_q;
  logic [ipr_pkg::FLD_W-1:0]                  level_q;
  logic [ipr_pkg::SRC_W-1:0]                  src_q;

  // True when an index names one of the seven registers
  function automatic logic addr_mapped(input logic [ipr_pkg::ADDR_W-1:0] a);
    addr_mapped = (a <= ipr_pkg::REG_CTRL_8);
  endfunction : addr_mapped

  // Builds a register image from the fields it holds.
  // Positions with no field stay zero, so reserved bits
  // and whole unmapped addresses read as zero.
  function automatic logic [ipr_pkg::REG_W-1:0] reg_image(
    input logic [ipr_pkg::ADDR_W-1:0]                  a,
    input logic [ipr_pkg::NUM_SRC*ipr_pkg::FLD_W-1:0]  p
  );
    logic [ipr_pkg::REG_W-1:0] w;
    w = '0;
    for (int k = 0; k < ipr_pkg::NUM_SRC; k++) begin
      if (ipr_pkg::FLD_REG[k] == a) begin
        w[ipr_pkg::FLD_LSB[k] +: ipr_pkg::FLD_W] =
          p[k*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];
      end
    end
    reg_image = w;
  endfunction : reg_image

  // One field register per source. The write strobe only reaches the
  // field whose register is addressed, so writes to reserved bits land
  // nowhere and the field layout comes from the package table alone.
  for (genvar g = 0; g < ipr_pkg::NUM_SRC; g++) begin : g_field
    logic fld_we;                                  // Write to this field
    assign fld_we = i_ce && i_wr && (i_addr == ipr_pkg::FLD_REG[g]);
    ipr_field u_field (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_we    (fld_we),
      .i_wdata (i_wdata[ipr_pkg::FLD_LSB[g] +: ipr_pkg::FLD_W]),
      .o_prio  (prio_all[g*ipr_pkg::FLD_W +: ipr_pkg::FLD_W])
    );
  end

  // Register two: receive 1, SPI A event and fault, timer C
  assign o_serial1_rx_prio       = prio_all[0*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];
  assign o_spi_a_event_prio      = prio_all[1*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];
  assign o_spi_a_fault_prio      = prio_all[2*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];
  assign o_timer_c_prio          = prio_all[3*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];

  // Register three: conversion done, transmit 1
  assign o_convert_done_prio     = prio_all[4*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];
  assign o_serial1_tx_prio       = prio_all[5*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];

  // Register four: input change, comparator, two-wire A
  assign o_input_change_prio     = prio_all[6*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];
  assign o_comparator_prio       = prio_all[7*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];
  assign o_twowire_a_master_prio = prio_all[8*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];
  assign o_twowire_a_slave_prio  = prio_all[9*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];

  // Register five: capture H and G, external line B
  assign o_capture_h_prio        = prio_all[10*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];
  assign o_capture_g_prio        = prio_all[11*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];
  assign o_ext_line_b_prio       = prio_all[12*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];

  // Register six: timer D, compare D and C
  assign o_timer_d_prio          = prio_all[13*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];
  assign o_compare_d_prio        = prio_all[14*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];
  assign o_compare_c_prio        = prio_all[15*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];

  // Register seven: transmit 2, receive 2, external line C, timer E
  assign o_serial2_tx_prio       = prio_all[16*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];
  assign o_serial2_rx_prio       = prio_all[17*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];
  assign o_ext_line_c_prio       = prio_all[18*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];
  assign o_timer_e_prio          = prio_all[19*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];

  // Register eight: SPI B event and fault
  assign o_spi_b_event_prio      = prio_all[20*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];
  assign o_spi_b_fault_prio      = prio_all[21*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];

  // A source competes only while both its flag and enable are set
  assign pending = i_flag & i_enable;

  // Largest field value among pending sources wins; the value itself is
  // the level, 1 lowest through 7 highest, with no remapping
  ipr_arbiter u_arbiter (
    .i_prio    (prio_all),
    .i_pending (pending),
    .o_valid   (win_valid),
    .o_level   (win_level),
    .o_src     (win_src)
  );

  // Image of the addressed register, zero for unmapped indices
  always_comb begin
    if (addr_mapped(i_addr)) begin
      rd_word = reg_image(i_addr, prio_all);
    end else begin
      rd_word = '0;
    end
  end

  // Read data: captured on an enabled read strobe, valid in the next cycle;
  // zeroed by each enabled cycle without a read, held while i_ce is low
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= '0;
    end else if (i_ce) begin
      if (i_rd) begin
        rdata_q <= rd_word;
      end else begin
        rdata_q <= '0;
      end
    end
  end

  // Request outputs are registered; this costs one cycle of latency
  // but keeps the processor side free of the arbiter's long compare chain
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      req_q   <= 1'b0;
      level_q <= ipr_pkg::PRIO_OFF;
      src_q   <= '0;
    end else if (i_ce) begin
      req_q   <= win_valid;
      level_q <= win_level;
      src_q   <= win_src;
    end
  end

  // Drive the ports from the flops
  assign o_rdata     = rdata_q;
  assign o_irq_req   = req_q;
  assign o_irq_level = level_q;
  assign o_irq_src   = src_q;

endmodule : ipr_bank

//--- ipr_pkg.sv
// Purpose: Shared constants for the interrupt priority register bank
// Assumes: 16-bit registers, 3-bit priority fields, one register per address
// Notes:   Source numbering below is used by the bank, the arbiter and the field map
package ipr_pkg;

  // Widths
  localparam int NUM_SRC = 22;                 // Priority fields in this bank
  localparam int NUM_REG = 7;                  // Priority registers in this bank
  localparam int FLD_W   = 3;                  // Bits per priority field
  localparam int REG_W   = 16;                 // Register data width
  localparam int ADDR_W  = 3;                  // Register index width
  localparam int SRC_W   = 5;                  // Width of a source number

  // Field values
  localparam logic [FLD_W-1:0] PRIO_RESET = 3'h4;   // Mid priority after power-on
  localparam logic [FLD_W-1:0] PRIO_OFF   = 3'h0;   // Source disabled
  localparam logic [FLD_W-1:0] PRIO_MAX   = 3'h7;   // Highest priority

  // Register indices on the register port
  localparam logic [ADDR_W-1:0] REG_CTRL_2 = 3'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL_3 = 3'h1;
  localparam logic [ADDR_W-1:0] REG_CTRL_4 = 3'h2;
  localparam logic [ADDR_W-1:0] REG_CTRL_5 = 3'h3;
  localparam logic [ADDR_W-1:0] REG_CTRL_6 = 3'h4;
  localparam logic [ADDR_W-1:0] REG_CTRL_7 = 3'h5;
  localparam logic [ADDR_W-1:0] REG_CTRL_8 = 3'h6;

  // Field bit positions inside a register
  localparam int LSB_HI  = 12;                 // Bits 14-12
  localparam int LSB_MH  = 8;                  // Bits 10-8
  localparam int LSB_ML  = 4;                  // Bits 6-4
  localparam int LSB_LO  = 0;                  // Bits 2-0

  // Register holding each source, indexed by source number
  localparam logic [ADDR_W-1:0] FLD_REG [NUM_SRC] = '{
    REG_CTRL_2, REG_CTRL_2, REG_CTRL_2, REG_CTRL_2,
    REG_CTRL_3, REG_CTRL_3,
    REG_CTRL_4, REG_CTRL_4, REG_CTRL_4, REG_CTRL_4,
    REG_CTRL_5, REG_CTRL_5, REG_CTRL_5,
    REG_CTRL_6, REG_CTRL_6, REG_CTRL_6,
    REG_CTRL_7, REG_CTRL_7, REG_CTRL_7, REG_CTRL_7,
    REG_CTRL_8, REG_CTRL_8};

  // Low bit of each source's field
  localparam int FLD_LSB [NUM_SRC] = '{
    LSB_HI, LSB_MH, LSB_ML, LSB_LO,
    LSB_ML, LSB_LO,
    LSB_HI, LSB_MH, LSB_ML, LSB_LO,
    LSB_HI, LSB_MH, LSB_LO,
    LSB_HI, LSB_MH, LSB_ML,
    LSB_HI, LSB_MH, LSB_ML, LSB_LO,
    LSB_ML, LSB_LO};

endpackage : ipr_pkg

//--- ipr_field.sv
// Purpose: One 3-bit priority field with software write
// Assumes: Write enable already qualified by address and clock enable
// Notes:   Power-on value is the mid priority
`timescale 1ns/10ps
module ipr_field (
  // Clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  // Write side
  input  wire logic                      i_we,
  input  wire logic [ipr_pkg::FLD_W-1:0] i_wdata,
  // Stored value
  output logic      [ipr_pkg::FLD_W-1:0] o_prio
);

  // Field storage; every value is legal, zero means disabled
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prio <= ipr_pkg::PRIO_RESET;
    end else if (i_we) begin
      o_prio <= i_wdata;
    end
  end

endmodule : ipr_field

//--- ipr_arbiter.sv
// Purpose: Picks the pending source with the largest priority value
// Assumes: Pending already means flag and enable both set
// Notes:   Purely combinational; ties go to the lower source number
`timescale 1ns/10ps
module ipr_arbiter (
  // Per-source inputs
  input  wire logic [ipr_pkg::NUM_SRC*ipr_pkg::FLD_W-1:0] i_prio,
  input  wire logic [ipr_pkg::NUM_SRC-1:0]                i_pending,
  // Winner
  output logic                                            o_valid,
  output logic      [ipr_pkg::FLD_W-1:0]                  o_level,
  output logic      [ipr_pkg::SRC_W-1:0]                  o_src
);

  // Linear scan; strict greater keeps the first of equal levels
  always_comb begin
    o_valid = 1'b0;
    o_level = ipr_pkg::PRIO_OFF;
    o_src   = '0;
    for (int k = 0; k < ipr_pkg::NUM_SRC; k++) begin
      // A zero field never beats the idle level, so it cannot request
      if (i_pending[k] && (i_prio[k*ipr_pkg::FLD_W +: ipr_pkg::FLD_W] > o_level)) begin
        o_valid = 1'b1;
        o_level = i_prio[k*ipr_pkg::FLD_W +: ipr_pkg::FLD_W];
        o_src   = k[ipr_pkg::SRC_W-1:0];
      end
    end
  end

endmodule : ipr_arbiter

//--- ipr_bank_properties.sv
// Purpose: Port checks for the priority register bank
// Assumes: One clock, reset active high, register port answers in one cycle
// Notes:   Only two field outputs are watched, to keep the checker small
`timescale 1ns/10ps
module ipr_bank_props (
  // Clock, reset, enable
  input wire logic                        i_clk,
  input wire logic                        i_rst,
  input wire logic                        i_ce,
  // Register port
  input wire logic [ipr_pkg::ADDR_W-1:0]  i_addr,
  input wire logic [ipr_pkg::REG_W-1:0]   i_wdata,
  input wire logic                        i_wr,
  input wire logic                        i_rd,
  input wire logic [ipr_pkg::REG_W-1:0]   o_rdata,
  // Sources and request
  input wire logic [ipr_pkg::NUM_SRC-1:0] i_flag,
  input wire logic [ipr_pkg::NUM_SRC-1:0] i_enable,
  input wire logic                        o_irq_req,
  input wire logic [ipr_pkg::FLD_W-1:0]   o_irq_level,
  input wire logic [ipr_pkg::SRC_W-1:0]   o_irq_src,
  // Watched fields of register two
  input wire logic [ipr_pkg::FLD_W-1:0]   o_serial1_rx_prio,
  input wire logic [ipr_pkg::FLD_W-1:0]   o_timer_c_prio
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Qualified strobes; a strobe with the enable low is not taken
  logic rd_go;
  logic wr_go;
  assign rd_go = i_ce & i_rd;
  assign wr_go = i_ce & i_wr;
  AST_RD_IDLE: assert property (i_ce && !i_rd |=> o_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  AST_RD_GAPS: assert property (rd_go |=> (o_rdata & 16'h8888) == 16'h0000)
    else $error("gap bit read as one");
  AST_RD_UNMAP: assert property (rd_go && i_addr == 3'h7 |=> o_rdata == 16'h0000)
    else $error("unmapped index read not zero");
  AST_REG3_TOP: assert property (rd_go && i_addr == ipr_pkg::REG_CTRL_3 |=> o_rdata[15:7] == 9'h000)
    else $error("register three upper bits not zero");
  AST_REG5_MID: assert property (rd_go && i_addr == ipr_pkg::REG_CTRL_5 |=> o_rdata[7:3] == 5'h00)
    else $error("register five middle bits not zero");
  AST_REG6_LOW: assert property (rd_go && i_addr == ipr_pkg::REG_CTRL_6 |=> o_rdata[3:0] == 4'h0)
    else $error("register six low bits not zero");
  AST_WR_HI: assert property (wr_go && i_addr == ipr_pkg::REG_CTRL_2
    |=> o_serial1_rx_prio == $past(i_wdata[14:12]))
    else $error("receive field not written");
  AST_WR_LO: assert property (wr_go && i_addr == ipr_pkg::REG_CTRL_2
    |=> o_timer_c_prio == $past(i_wdata[2:0]))
    else $error("timer field not written");
  AST_READBACK: assert property (wr_go && i_addr == ipr_pkg::REG_CTRL_2 ##1 rd_go && i_addr == ipr_pkg::REG_CTRL_2
    |=> o_rdata == ($past(i_wdata, 2) & 16'h7777))
    else $error("read after write differs");
  AST_NO_REQ: assert property (!o_irq_req |-> o_irq_level == 3'h0 && o_irq_src == 5'h00)
    else $error("level or source without request");
  AST_REQ_LVL: assert property (o_irq_req |-> o_irq_level != 3'h0)
    else $error("request at level zero");
  AST_IDLE_REQ: assert property (i_ce && (i_flag & i_enable) == '0 |=> !o_irq_req)
    else $error("request with nothing pending");
endmodule : ipr_bank_props

//--- ipr_bank_test.sv
// Purpose: Self-checking bench for the priority register bank
// Assumes: Register indices and reset images as handed over
// Notes:   Expected field positions come from the bench's own map
`timescale 1ns/10ps
module ipr_bank_test;
  // Design inputs
  logic                        i_clk, i_rst, i_ce, i_wr, i_rd;
  logic [ipr_pkg::ADDR_W-1:0]  i_addr;
  logic [ipr_pkg::REG_W-1:0]   i_wdata;
  logic [ipr_pkg::NUM_SRC-1:0] i_flag, i_enable;
  // Design outputs
  logic [ipr_pkg::REG_W-1:0]   o_rdata;
  logic                        o_irq_req;
  logic [ipr_pkg::FLD_W-1:0]   o_irq_level;
  logic [ipr_pkg::SRC_W-1:0]   o_irq_src;
  logic [ipr_pkg::FLD_W-1:0]   prio [22];  // Field outputs by source number
  // Own map: register index and low bit of each source
  int sreg [22] = '{0,0,0,0,1,1,2,2,2,2,3,3,3,4,4,4,5,5,5,5,6,6};
  int slsb [22] = '{12,8,4,0,4,0,12,8,4,0,12,8,0,12,8,4,12,8,4,0,4,0};
  // Power-on images, fields at binary 100
  logic [15:0] img [7] = '{16'h4444,16'h0044,16'h4444,16'h4404,16'h4440,16'h4444,16'h0044};
  logic [15:0] pat [7];  // Patterns written in the second phase
  int          n_mismatch, comparisons, cycles;
  ipr_bank dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_flag(i_flag), .i_enable(i_enable),
    .o_irq_req(o_irq_req), .o_irq_level(o_irq_level), .o_irq_src(o_irq_src),
    .o_serial1_rx_prio(prio[0]), .o_spi_a_event_prio(prio[1]), .o_spi_a_fault_prio(prio[2]),
    .o_timer_c_prio(prio[3]), .o_convert_done_prio(prio[4]), .o_serial1_tx_prio(prio[5]),
    .o_input_change_prio(prio[6]), .o_comparator_prio(prio[7]),
    .o_twowire_a_master_prio(prio[8]), .o_twowire_a_slave_prio(prio[9]),
    .o_capture_h_prio(prio[10]), .o_capture_g_prio(prio[11]), .o_ext_line_b_prio(prio[12]),
    .o_timer_d_prio(prio[13]), .o_compare_d_prio(prio[14]), .o_compare_c_prio(prio[15]),
    .o_serial2_tx_prio(prio[16]), .o_serial2_rx_prio(prio[17]), .o_ext_line_c_prio(prio[18]),
    .o_timer_e_prio(prio[19]), .o_spi_b_event_prio(prio[20]), .o_spi_b_fault_prio(prio[21]));
  // 10 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // Hang guard; the whole run needs under a hundred cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Write, read, and write then read with no gap
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 check("rdata", o_rdata, exp);
  endtask : rd
  task automatic wrrd(input logic [2:0] a, input logic [15:0] d, input logic [15:0] exp);
    wr(a, d);
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 check("readback", o_rdata, exp);
  endtask : wrrd
  // Flags applied, request packed as req, level, source
  task automatic irq(input logic [21:0] f, input logic [21:0] e, input logic [15:0] exp);
    @(posedge i_clk);
    i_flag <= f;
    i_enable <= e;
    repeat (2) @(posedge i_clk);
    #1 check("irq", {7'h00, o_irq_req, o_irq_level, o_irq_src}, exp);
  endtask : irq
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  initial begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    i_flag = '0;
    i_enable = '0;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int r = 0; r < 7; r++) rd(r[2:0], img[r]);
    for (int s = 0; s < 22; s++) check("field", {13'h0, prio[s]}, 16'h0004);
    rd(3'h7, 16'h0000);
    // Distinct values 1..7 in the fields, every gap bit set
    for (int r = 0; r < 7; r++) begin
      pat[r] = 16'h8888;
      for (int k = 0; k < 4; k++) pat[r] = pat[r] | 16'((((r + k) % 7) + 1) << (12 - 4 * k));
      wrrd(r[2:0], pat[r], pat[r] & ((img[r] >> 2) * 16'h0007));
    end
    wr(3'h7, 16'hFFFF);
    for (int s = 0; s < 22; s++)
      check("field", {13'h0, prio[s]}, (pat[sreg[s]] >> slsb[s]) & 16'h0007);
    // Strobe with the enable low is dropped
    i_ce <= 1'b0;
    wr(3'h0, 16'h0000);
    i_ce <= 1'b1;
    rd(3'h0, 16'h1234);
    // Sources 0-3 off, 20 at 7, 21 at 1, 16 at 7
    wr(3'h0, 16'h0000);
    wr(3'h6, 16'h0071);
    wr(3'h5, 16'h7000);
    irq(22'h000008, 22'h000008, 16'h0000);
    irq(22'h300000, 22'h3FFFFF, 16'h01F4);
    irq(22'h200000, 22'h3FFFFF, 16'h0135);
    irq(22'h300000, 22'h200000, 16'h0135);
    irq(22'h110000, 22'h3FFFFF, 16'h01F0);
    irq(22'h3FFFFF, 22'h3FFFFF, 16'h01EC);
    irq(22'h000000, 22'h3FFFFF, 16'h0000);
    // Second reset in mid-run
    i_rst <= 1'b1;
    @(posedge i_clk);
    i_rst <= 1'b0;
    rd(3'h5, 16'h4444);
    give_verdict();
  end
endmodule : ipr_bank_test
bind ipr_bank ipr_bank_props props_u (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_flag(i_flag), .i_enable(i_enable), .o_irq_req(o_irq_req), .o_irq_level(o_irq_level),
  .o_irq_src(o_irq_src), .o_serial1_rx_prio(o_serial1_rx_prio), .o_timer_c_prio(o_timer_c_prio));
